// ### hdl/swm_pkg.sv
// Purpose: shared constants and types of the supervisor watchdog block
// Assumes: 10 MHz clock, APB register access with 32-bit data
// Notes:   times are kept in their own unit, cycle counts derived here
package swm_pkg;

  // ----------------------------------------------------------------
  // clock and bus
  // ----------------------------------------------------------------
  localparam int CLK_HZ        = 10_000_000;
  localparam int CYC_PER_MS    = CLK_HZ / 1000;
  localparam int ADDR_W        = 8;
  localparam int DATA_W        = 32;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_CAP    = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_TMIN   = 8'h08;
  localparam logic [ADDR_W-1:0] REG_TMAX   = 8'h0C;

  localparam int              CAP_W     = 14;
  localparam logic [CAP_W-1:0] CAP_RESET = 14'h000A;

  localparam int ST_RESET  = 0;
  localparam int ST_FAULT  = 1;
  localparam int ST_VALID  = 2;
  localparam int ST_SETUP  = 3;
  localparam int ST_MODE   = 4;
  localparam int ST_EXT    = 6;

  // ----------------------------------------------------------------
  // timeout selection
  // ----------------------------------------------------------------
  localparam logic [1:0] CFG_OPEN   = 2'h0;
  localparam logic [1:0] CFG_PULLUP = 2'h1;
  localparam logic [1:0] CFG_CAP    = 2'h2;

  localparam int T_FIX_LONG_MS  = 1600;
  localparam int T_FIX_SHORT_MS = 200;
  localparam int FIX_TOL_PCT    = 15;
  localparam int PERMILLE       = 1000;
  localparam int FIX_MIN_PM     = PERMILLE - 10 * FIX_TOL_PCT;
  localparam int FIX_MAX_PM     = PERMILLE + 10 * FIX_TOL_PCT;
  localparam int CAP_MIN_PM     = 905;
  localparam int CAP_MAX_PM     = 1095;
  localparam int US_PER_MS      = 1000;

  // capacitor in steps of 100 pF: 3.23 ms/nF = 323 us per step
  localparam int STD_SLOPE_US   = 323;
  localparam int STD_OFFSET_US  = 381;
  localparam int EXT_SLOPE_US   = 7740;
  localparam int EXT_OFFSET_US  = 55000;

  // ----------------------------------------------------------------
  // fixed timing
  // ----------------------------------------------------------------
  localparam int SETUP_US       = 150;
  localparam int SETUP_CYC      = (SETUP_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int RST_HOLD_MS    = 200;
  localparam int GLITCH_SHALLOW_US  = 20;
  localparam int GLITCH_DEEP_US     = 2;
  localparam int GLITCH_SHALLOW_CYC =
    (GLITCH_SHALLOW_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int GLITCH_DEEP_CYC    =
    (GLITCH_DEEP_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int GLITCH_W           = 12;

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SUP_HOLD  = 3'b001,
    SUP_DELAY = 3'b010,
    SUP_RUN   = 3'b100
  } swm_sup_t;

  typedef enum logic [3:0] {
    WD_OFF    = 4'b0001,
    WD_SETUP  = 4'b0010,
    WD_TIMING = 4'b0100,
    WD_FAULT  = 4'b1000
  } swm_wd_t;

endpackage : swm_pkg

// ### hdl/swm_uv_if.sv
// Purpose: carrier between supervisor and undervoltage filter
// Assumes: single clock domain
// Notes:   none
`timescale 1ns/10ps
interface swm_uv_if;
  logic belowTrip;
  logic deepDip;
  logic uvConfirmed;

  modport filt (input belowTrip, input deepDip, output uvConfirmed);
  modport sup  (output belowTrip, output deepDip, input uvConfirmed);
endinterface : swm_uv_if

// ### hdl/swm_uv_filter.sv
// Purpose: persistence filter for the undervoltage comparator
// Assumes: comparator flags synchronous to clock
// Notes:   deeper dip confirms sooner
`timescale 1ns/10ps
module swm_uv_filter (
  input  wire logic clock,
  input  wire logic rst,
  swm_uv_if.filt    uv
);
  import swm_pkg::*;

  logic [GLITCH_W-1:0] dipCount;
  logic [GLITCH_W-1:0] dipLimit;

  // ----------------------------------------------------------------
  // dip duration
  // ----------------------------------------------------------------
  always_comb begin
    dipLimit = uv.deepDip ? GLITCH_W'(GLITCH_DEEP_CYC - 1)
                          : GLITCH_W'(GLITCH_SHALLOW_CYC - 1);
  end

  // brief dips below the trip level are swallowed here
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dipCount       <= '0;
      uv.uvConfirmed <= 1'b0;
    end else if (!uv.belowTrip) begin
      dipCount       <= '0;
      uv.uvConfirmed <= 1'b0;
    end else if (dipCount >= dipLimit) begin
      uv.uvConfirmed <= 1'b1;
    end else begin
      dipCount <= dipCount + GLITCH_W'(1);
    end
  end

endmodule : swm_uv_filter

// ### hdl/swm_supervisor.sv
// Purpose: supply supervisor with watchdog and APB status registers
// Assumes: supply comparators arrive as synchronous flags
// Notes:   open-drain pins are split into out and output enable
`timescale 1ns/10ps

// Contract
// - below minimum operating supply, reset output held low.
// - while reset is asserted, fault output released, kicks ignored.
// - above minimum supply, reset follows only the supply comparison.
// - before first rise above upper threshold, ignore kicks, reset low.
// - fault output goes low when kick interval reaches minimum timeout.
// - open config pin gives 1600 ms, pulled up gives 200 ms.
// - fixed timeouts use window of plus or minus fifteen percent.
// - capacitor on config pin selects timeout computed from capacitance.
// - standard timing is 3.23 ms per nF plus 0.381 ms.
// - extended timing is 77.4 ms per nF plus 55 ms.
// - reset asserts only on persisting dip, sooner when deeper.
// - enable low disables watchdog and ignores all kicks.
// - after enabling, kicks ignored for 150 us setup time; code skips setup if enable was already high when reset released.
// - fault output stays low for reset-hold delay, then releases.
// - after supply rises above upper threshold, reset held for delay.
module swm_supervisor #(
  parameter bit EXTENDED   = 1'b0,
  parameter int CYC_MS     = swm_pkg::CYC_PER_MS,
  parameter int HOLD_MS    = swm_pkg::RST_HOLD_MS
) (
  input  wire logic                       clock,
  input  wire logic                       rst,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [swm_pkg::ADDR_W-1:0] paddr,
  input  wire logic [swm_pkg::DATA_W-1:0] pwdata,
  output logic      [swm_pkg::DATA_W-1:0] prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       vddMinOk,
  input  wire logic                       vddBelowThreshold,
  input  wire logic                       vddAboveUpper,
  input  wire logic                       vddDeepDip,
  input  wire logic [1:0]                 timeoutConfigPin,
  input  wire logic                       watchdogKickInput,
  input  wire logic                       watchdogEnableInput,
  output logic                            resetOut,
  output logic                            resetOe,
  output logic                            watchdogFaultOutput,
  output logic                            watchdogFaultOe
);
  import swm_pkg::*;

  localparam logic [31:0] HOLD_CYC = 32'(HOLD_MS * CYC_MS);

  swm_sup_t          supState;
  swm_wd_t           wdState;
  logic [31:0]       supCount;
  logic [31:0]       wdCount;
  logic              everValid;
  logic              enterValid;
  logic              kickPrev;
  logic              kickFall;
  logic              enPrev;
  logic [1:0]        cfgMode;
  logic [CAP_W-1:0]  capReg;
  logic [31:0]       tMin;
  logic [31:0]       tMax;
  logic [DATA_W-1:0] readWord;
  logic              readHit;
  logic              accessDone;

  swm_uv_if uvLink ();

  assign uvLink.belowTrip = vddBelowThreshold;
  assign uvLink.deepDip   = vddDeepDip;

  swm_uv_filter uvFilter (
    .clock (clock),
    .rst   (rst),
    .uv    (uvLink.filt)
  );

  // ----------------------------------------------------------------
  // timeout arithmetic
  // ----------------------------------------------------------------
  // 64-bit math: extended typical at 1 uF times cycles overflows 32
  function automatic logic [31:0] swm_limit(
    input logic [1:0]       mode,
    input logic [CAP_W-1:0] capN,
    input logic             isMax
  );
    logic [63:0] tUs;
    logic [63:0] perMille;
    logic [63:0] scaled;
    logic [63:0] divisor;
    logic [63:0] cyc;
    tUs      = '0;
    perMille = '0;
    divisor  = 64'(US_PER_MS) * 64'(PERMILLE);
    if (mode == CFG_CAP) begin
      if (EXTENDED) begin
        tUs = 64'(capN) * 64'(EXT_SLOPE_US) + 64'(EXT_OFFSET_US);
      end else begin
        tUs = 64'(capN) * 64'(STD_SLOPE_US) + 64'(STD_OFFSET_US);
      end
      perMille = isMax ? 64'(CAP_MAX_PM) : 64'(CAP_MIN_PM);
    end else begin
      if (mode == CFG_PULLUP) begin
        tUs = 64'(T_FIX_SHORT_MS) * 64'(US_PER_MS);
      end else begin
        tUs = 64'(T_FIX_LONG_MS) * 64'(US_PER_MS);
      end
      perMille = isMax ? 64'(FIX_MAX_PM) : 64'(FIX_MIN_PM);
    end
    scaled = tUs * perMille * 64'(CYC_MS);
    // least time rounds up, longest rounds down
    if (isMax) begin
      cyc = scaled / divisor;
    end else begin
      cyc = (scaled + divisor - 64'(1)) / divisor;
    end
    if (cyc == 64'(0)) begin
      cyc = 64'(1);
    end
    return cyc[31:0];
  endfunction : swm_limit

  // ----------------------------------------------------------------
  // supply supervisor
  // ----------------------------------------------------------------
  assign enterValid = (supState == SUP_HOLD) && vddMinOk && vddAboveUpper
                      && !uvLink.uvConfirmed;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      supState <= SUP_HOLD;
      supCount <= '0;
      resetOe  <= 1'b1;
    end else if (!vddMinOk) begin
      supState <= SUP_HOLD;
      supCount <= '0;
      resetOe  <= 1'b1;
    end else begin
      unique case (supState)
        SUP_HOLD: begin
          // stays low until first rise above upper threshold
          if (enterValid) begin
            supState <= SUP_DELAY;
            supCount <= '0;
          end
          resetOe <= 1'b1;
        end
        SUP_DELAY: begin
          if (uvLink.uvConfirmed) begin
            supState <= SUP_HOLD;
            resetOe  <= 1'b1;
          end else if (supCount >= HOLD_CYC - 32'(1)) begin
            supState <= SUP_RUN;
            resetOe  <= 1'b0;
          end else begin
            supCount <= supCount + 32'(1);
            resetOe  <= 1'b1;
          end
        end
        SUP_RUN: begin
          if (uvLink.uvConfirmed) begin
            supState <= SUP_HOLD;
            resetOe  <= 1'b1;
          end else begin
            resetOe  <= 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      everValid <= 1'b0;
    end else if (enterValid) begin
      everValid <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // timeout selection latch
  // ----------------------------------------------------------------
  // changing the pin or register mid-run has no effect until next entry
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfgMode <= CFG_OPEN;
      tMin    <= '0;
      tMax    <= '0;
    end else if (enterValid) begin
      cfgMode <= timeoutConfigPin;
      tMin    <= swm_limit(timeoutConfigPin, capReg, 1'b0);
      tMax    <= swm_limit(timeoutConfigPin, capReg, 1'b1);
    end
  end

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  assign kickFall = kickPrev && !watchdogKickInput;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      kickPrev <= 1'b0;
      enPrev   <= 1'b0;
    end else begin
      kickPrev <= watchdogKickInput;
      enPrev   <= watchdogEnableInput;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wdState         <= WD_OFF;
      wdCount         <= '0;
      watchdogFaultOe <= 1'b0;
    end else if (supState != SUP_RUN || !everValid) begin
      wdState         <= WD_OFF;
      wdCount         <= '0;
      watchdogFaultOe <= 1'b0;
    end else if (!watchdogEnableInput) begin
      wdState         <= WD_OFF;
      wdCount         <= '0;
      watchdogFaultOe <= 1'b0;
    end else begin
      unique case (wdState)
        WD_OFF: begin
          wdCount <= '0;
          if (enPrev) begin
            wdState <= WD_TIMING;
          end else begin
            wdState <= WD_SETUP;
          end
        end
        WD_SETUP: begin
          if (wdCount >= 32'(SETUP_CYC - 1)) begin
            wdState <= WD_TIMING;
            wdCount <= '0;
          end else begin
            wdCount <= wdCount + 32'(1);
          end
        end
        WD_TIMING: begin
          // interval counted inclusive of this cycle
          if (wdCount >= tMin - 32'(1)) begin
            wdState         <= WD_FAULT;
            wdCount         <= '0;
            watchdogFaultOe <= 1'b1;
          end else if (kickFall) begin
            wdCount <= '0;
          end else begin
            wdCount <= wdCount + 32'(1);
          end
        end
        WD_FAULT: begin
          if (wdCount >= HOLD_CYC - 32'(1)) begin
            wdState         <= WD_TIMING;
            wdCount         <= '0;
            watchdogFaultOe <= 1'b0;
          end else begin
            wdCount <= wdCount + 32'(1);
          end
        end
      endcase
    end
  end

  // open-drain pins only ever pull low
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      resetOut            <= 1'b0;
      watchdogFaultOutput <= 1'b0;
    end else begin
      resetOut            <= 1'b0;
      watchdogFaultOutput <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign accessDone = psel && penable && pready;

  always_comb begin
    readWord = '0;
    readHit  = 1'b1;
    unique case (paddr)
      REG_CAP: begin
        readWord[CAP_W-1:0] = capReg;
      end
      REG_STATUS: begin
        readWord[ST_RESET]          = resetOe;
        readWord[ST_FAULT]          = watchdogFaultOe;
        readWord[ST_VALID]          = everValid;
        readWord[ST_SETUP]          = (wdState == WD_SETUP);
        readWord[ST_MODE+1:ST_MODE] = cfgMode;
        readWord[ST_EXT]            = EXTENDED;
      end
      REG_TMIN: begin
        readWord = tMin;
      end
      REG_TMAX: begin
        readWord = tMax;
      end
      default: begin
        readHit = 1'b0;
      end
    endcase
  end

  // one wait state: pready rises on second access cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      prdata  <= pwrite ? '0 : readWord;
      pslverr <= !readHit || (pwrite && paddr != REG_CAP);
    end else begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      capReg <= CAP_RESET;
    end else if (accessDone && pwrite && paddr == REG_CAP) begin
      capReg <= pwdata[CAP_W-1:0];
    end
  end

endmodule : swm_supervisor

// ### dv/swm_host_model.sv
// Purpose: host processor that services the watchdog kick pin
// Assumes: the block counts falling edges of the kick
// Notes:   idles high, so no stray edge while stopped
`timescale 1ns/10ps
module swm_host_model (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        run,
  input  wire logic [15:0] period,
  output logic             kick
);
  // ----------------------------------------------------------------
  // kick generator
  // ----------------------------------------------------------------
  logic [15:0] cnt;

  // one low cycle every period cycles; a long period is a slow host
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt  <= 16'h0;
      kick <= 1'b1;
    end else if (!run) begin
      cnt  <= 16'h0;
      kick <= 1'b1;
    end else begin
      cnt  <= (cnt >= period - 16'h1) ? 16'h0 : cnt + 16'h1;
      kick <= (cnt != period - 16'h1);
    end
  end
endmodule : swm_host_model

// ### dv/swm_supervisor_properties.sv
// Purpose: port properties of the supervisor watchdog
// Assumes: one clock, rst asynchronous and active high
// Notes:   sees only ports of the top module
`timescale 1ns/10ps
module swm_supervisor_checker #(
  parameter int CYC_MS  = 10,
  parameter int HOLD_MS = 2
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic vddMinOk,
  input wire logic vddBelowThreshold,
  input wire logic vddAboveUpper,
  input wire logic vddDeepDip,
  input wire logic watchdogKickInput,
  input wire logic watchdogEnableInput,
  input wire logic resetOe,
  input wire logic watchdogFaultOe
);
  import swm_pkg::*;
  // ----------------------------------------------------------------
  // helper counters
  // ----------------------------------------------------------------
  localparam int HOLDC = HOLD_MS * CYC_MS;
  int   goodCnt;
  int   faultCnt;
  int   belowCnt;
  int   setupLeft;
  logic enLast;
  logic everUp;
  logic longDip;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      goodCnt  <= 0;
      faultCnt <= 0;
      belowCnt <= 0;
      everUp   <= 1'b0;
      longDip  <= 1'b0;
      setupLeft <= 0;
      enLast    <= 1'b0;
    end else begin
      goodCnt  <= (resetOe && vddMinOk && !vddBelowThreshold) ?
                  goodCnt + 1 : 0;
      faultCnt <= watchdogFaultOe ? faultCnt + 1 : 0;
      belowCnt <= vddBelowThreshold ? belowCnt + 1 : 0;
      everUp   <= everUp | (vddMinOk & vddAboveUpper);
      // dip long enough to count; cleared once reset has answered it
      longDip  <= resetOe ? 1'b0 : longDip | (vddBelowThreshold &&
                  belowCnt >= (vddDeepDip ? GLITCH_DEEP_CYC
                               : GLITCH_SHALLOW_CYC) - 1);
      enLast    <= watchdogEnableInput;
      // setup window only opens when enabling with reset released
      setupLeft <= (!watchdogEnableInput || resetOe) ? 0
                 : !enLast ? SETUP_CYC
                 : (setupLeft > 0) ? setupLeft - 1 : 0;
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  sequence s_kickFall;
    $fell(watchdogKickInput);
  endsequence
  sequence s_faultEnd;
    $fell(watchdogFaultOe) && watchdogEnableInput && !resetOe;
  endsequence

  property p_lowSupply;  !vddMinOk |=> resetOe; endproperty
  property p_faultRel;   resetOe ##1 resetOe |-> !watchdogFaultOe; endproperty
  property p_supplyOnly;
    !resetOe && vddMinOk && !vddBelowThreshold &&
      !$past(vddBelowThreshold) |=> !resetOe;
  endproperty
  property p_notYetUp;   !everUp |-> resetOe && !watchdogFaultOe; endproperty
  property p_kickSaves;  s_kickFall |-> ##2 !$rose(watchdogFaultOe) [*3];
  endproperty
  property p_disabled;
    !watchdogEnableInput ##1 !watchdogEnableInput |-> !watchdogFaultOe;
  endproperty
  property p_setup;
    setupLeft > 0 |-> !watchdogFaultOe;
  endproperty
  property p_faultHold;
    s_faultEnd and $past(watchdogEnableInput) && !$past(resetOe)
      |-> faultCnt == HOLDC;
  endproperty
  property p_holdDelay;  $fell(resetOe) |-> goodCnt >= HOLDC; endproperty
  property p_dipFilter;  $rose(resetOe) && $past(vddMinOk) |-> longDip;
  endproperty

  a_lowSupply: assert property (p_lowSupply)
    else $error("reset not held at low supply");
  a_faultRel: assert property (p_faultRel)
    else $error("fault driven during reset");
  a_supplyOnly: assert property (p_supplyOnly)
    else $error("reset asserted with good supply");
  a_notYetUp: assert property (p_notYetUp)
    else $error("outputs wrong before first valid supply");
  a_kickSaves: assert property (p_kickSaves)
    else $error("fault soon after a kick");
  a_disabled: assert property (p_disabled)
    else $error("fault while disabled");
  a_setup: assert property (p_setup)
    else $error("fault inside setup time");
  a_faultHold: assert property (p_faultHold)
    else $error("fault hold length wrong");
  a_holdDelay: assert property (p_holdDelay)
    else $error("reset released before hold delay");
  a_dipFilter: assert property (p_dipFilter)
    else $error("reset on a short dip");
endmodule : swm_supervisor_checker

bind swm_supervisor swm_supervisor_checker #(
  .CYC_MS  (CYC_MS),
  .HOLD_MS (HOLD_MS)
) u_chk (
  .clock               (clock),
  .rst                 (rst),
  .vddMinOk            (vddMinOk),
  .vddBelowThreshold   (vddBelowThreshold),
  .vddAboveUpper       (vddAboveUpper),
  .vddDeepDip          (vddDeepDip),
  .watchdogKickInput   (watchdogKickInput),
  .watchdogEnableInput (watchdogEnableInput),
  .resetOe             (resetOe),
  .watchdogFaultOe     (watchdogFaultOe)
);

// ### dv/swm_supervisor_tb.sv
// Purpose: self-checking bench of the supervisor watchdog
// Assumes: CYC_MS and HOLD_MS shortened, supply given as flags
// Notes:   the extended timing build is not run here
`timescale 1ns/10ps
module swm_supervisor_tb;
  import swm_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam int CYC   = 10;
  localparam int HOLDC = 2 * CYC;
  typedef struct {
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic              err;
  } swm_row_t;
  logic              clock, rst, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic              vddMinOk, vddBelowThreshold, vddAboveUpper, vddDeepDip;
  logic [1:0]        timeoutConfigPin;
  logic              watchdogKickInput, watchdogEnableInput, kickRun;
  logic              resetOut, resetOe, watchdogFaultOutput, watchdogFaultOe;
  logic              err, kickPrev;
  logic [15:0]       kickPeriod;
  int                nMismatch = 0;
  int                comparisons = 0;
  int                cyc = 0;
  int                lastFall = 0;
  int                n, tMin;
  swm_row_t          rows [7] = '{
    '{1'b0, REG_CAP,    32'h0,        32'h0000000A, 1'b0},
    '{1'b1, REG_CAP,    32'h0000C003, 32'h0,        1'b0},
    '{1'b0, REG_CAP,    32'h0,        32'h00000003, 1'b0},
    '{1'b1, REG_STATUS, 32'h0,        32'h0,        1'b1},
    '{1'b1, REG_TMIN,   32'h0,        32'h0,        1'b1},
    '{1'b0, 8'h10,      32'h0,        32'h0,        1'b1},
    '{1'b1, REG_CAP,    32'h0000000A, 32'h0,        1'b0}};

  swm_supervisor #(.EXTENDED(1'b0), .CYC_MS(CYC), .HOLD_MS(2)) u_dut (.*);
  swm_host_model u_host (
    .clock  (clock),
    .rst    (rst),
    .run    (kickRun),
    .period (kickPeriod),
    .kick   (watchdogKickInput)
  );

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc      <= cyc + 1;
    kickPrev <= watchdogKickInput;
    if (kickPrev && !watchdogKickInput) lastFall <= cyc;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    if (nMismatch == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [DATA_W-1:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      nMismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d);
    int k;
    k = 0;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      nMismatch++;
      test_done();
    end
    @(posedge clock);
  endtask : apb

  task automatic waitSig(input bit flt, input logic lvl, input int lim,
                         output int cnt);
    cnt = 0;
    while (((flt ? watchdogFaultOe : resetOe) !== lvl) && cnt < lim) begin
      @(posedge clock);
      cnt++;
    end
    if (cnt >= lim) begin
      nMismatch++;
      test_done();
    end
  endtask : waitSig

  // window limit in cycles; capacitor mode uses 1 nF
  function automatic int lim(input int cfg, input bit mx);
    longint typ;
    longint pm;
    typ = (cfg == 0) ? T_FIX_LONG_MS * US_PER_MS
        : (cfg == 1) ? T_FIX_SHORT_MS * US_PER_MS : 3230 + 381;
    pm  = (cfg == 2) ? (mx ? 1095 : 905) : (mx ? 1150 : 850);
    return int'((typ * pm * CYC + (mx ? 0 : 999999)) / 1000000);
  endfunction : lim

  task automatic dip(input logic [1:0] cfg, input logic deep);
    logic was;
    int   g;
    was = resetOe;
    g   = deep ? GLITCH_DEEP_CYC : GLITCH_SHALLOW_CYC;
    vddBelowThreshold <= 1'b1;
    vddDeepDip        <= deep;
    vddAboveUpper     <= 1'b0;
    timeoutConfigPin  <= cfg;
    @(posedge clock);
    waitSig(1'b0, 1'b1, 400, n);
    if (!was) chk("dipLen", 32'(n inside {[g:g+2]}), 32'h1);
    @(posedge clock);
    chk("faultOff", 32'(watchdogFaultOe), 32'h0);
    vddBelowThreshold <= 1'b0;
    vddAboveUpper     <= 1'b1;
    @(posedge clock);
    waitSig(1'b0, 1'b0, 80, n);
    chk("hold", 32'(n inside {[HOLDC:HOLDC+6]}), 32'h1);
  endtask : dip

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {vddMinOk, vddBelowThreshold, vddAboveUpper, vddDeepDip} = 4'h0;
    timeoutConfigPin = CFG_PULLUP;
    watchdogEnableInput = 1'b1;
    kickRun = 1'b1;
    kickPeriod = 16'd20;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].addr, rows[i].wdata);
      chk("pslverr", 32'(err), 32'(rows[i].err));
      if (!rows[i].wr) chk("prdata", rd, rows[i].rdata);
    end
    apb(1'b0, REG_STATUS, '0);
    chk("status", rd & 32'h45, 32'h01);
    vddMinOk <= 1'b1;
    // capacitor kept at 1 nF, inside the supported range
    for (int c = 0; c < 3; c++) begin
      dip(2'(c), 1'b1);
      apb(1'b0, REG_TMIN, '0);
      chk("tmin", rd, 32'(lim(c, 1'b0)));
      apb(1'b0, REG_TMAX, '0);
      chk("tmax", rd, 32'(lim(c, 1'b1)));
      apb(1'b0, REG_STATUS, '0);
      chk("cfg", 32'(rd[5:4]), 32'(c));
    end
    tMin = lim(2, 1'b0);
    kickPeriod <= 16'd32;
    repeat (300) @(posedge clock);
    chk("slowKick", 32'(watchdogFaultOe), 32'h0);
    kickRun <= 1'b0;
    waitSig(1'b1, 1'b1, 100, n);
    chk("late", 32'((cyc-lastFall) inside {[tMin:tMin+1]}), 32'h1);
    waitSig(1'b1, 1'b0, 100, n);
    chk("faultLen", 32'(n), 32'(HOLDC));
    watchdogEnableInput <= 1'b0;
    repeat (100) @(posedge clock);
    chk("disabled", 32'(watchdogFaultOe), 32'h0);
    watchdogEnableInput <= 1'b1;
    waitSig(1'b1, 1'b1, 2000, n);
    chk("setup", 32'(n inside {[SETUP_CYC+tMin-1:SETUP_CYC+tMin+2]}),
        32'h1);
    vddDeepDip        <= 1'b0;
    vddBelowThreshold <= 1'b1;
    repeat (GLITCH_SHALLOW_CYC - 1) @(posedge clock);
    vddBelowThreshold <= 1'b0;
    repeat (4) @(posedge clock);
    chk("glitch", 32'(resetOe), 32'h0);
    dip(CFG_CAP, 1'b0);
    chk("pins", 32'({resetOut, watchdogFaultOutput}), 32'h0);
    test_done();
  end
endmodule : swm_supervisor_tb
